// File: hw/rx_noise_cfg.svh
// Constants for the receiver configuration and noise control block.
// Assumes a 40 MHz clock; word bit 1 is kept at index 14, bit 15 at index 0.
`ifndef RX_NOISE_CFG_SVH
`define RX_NOISE_CFG_SVH

// Clock period
`define CLK_PERIOD_PS 25000

// Programming word layout
`define WORD_BITS 15
`define W_OFF 14
`define W_ADDR 13
`define W_PAY_HI 12
`define W_PAY_LO 1
`define W_STOP 0

// Operating register fields and default 0001_0001_1001
`define OPCFG_RESET 12'h119
`define OP_BAND_HI 11
`define OP_BAND_LO 10
`define OP_CHK_HI 9
`define OP_CHK_LO 8
`define OP_MOD 7
`define OP_SLEEP_HI 6
`define OP_SLEEP_LO 2
`define OP_STRETCH 1
`define OP_SQUELCH 0

// Bit-window register fields, minimum 21 and maximum 41
`define LIMITS_RESET 12'h569
`define LIM_MIN_HI 11
`define LIM_MIN_LO 6
`define LIM_MAX_HI 5
`define LIM_MAX_LO 0

// Sleep interval terms
`define SLEEP_PERMANENT 5'h1F
`define SLEEP_UNIT 1024
`define SLEEP_STRETCH 8

// Times in ns and their counts in cycles
`define PROG_ENTRY_NS 2000
`define PROG_ENTRY_CYC ((`PROG_ENTRY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BIT_SPLIT_NS 1000
`define BIT_SPLIT_CYC ((`BIT_SPLIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define BIT_GAP_NS 50000
`define BIT_GAP_CYC ((`BIT_GAP_NS * 1000) / `CLK_PERIOD_PS)
`define STARTUP_NS 20000
`define STARTUP_CYC ((`STARTUP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TAIL_UNIT_NS 5000
`define TAIL_UNIT_CYC ((`TAIL_UNIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MARKER_NS 10000
`define MARKER_CYC ((`MARKER_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RESET_LOW_NS 20000000
`define RESET_LOW_CYC (`RESET_LOW_NS / (`CLK_PERIOD_PS / 1000))

`endif

// File: hw/rx_noise_pkg.sv
// Types for the receiver configuration and noise control block.
// Assumes the constants header is included by the design files.
package rx_noise_pkg;

  // Receiver modes, Gray coded along sleep, start-up, check, receive
  typedef enum logic [2:0] {
    ST_SLEEP = 3'b000,
    ST_STARTUP = 3'b001,
    ST_CHECK = 3'b011,
    ST_RECEIVE = 3'b010,
    ST_TAIL = 3'b110,
    ST_PROG = 3'b111
  } rx_state_t;

  // Programming word actions
  typedef enum logic [1:0] {
    ACT_OFF = 2'b00,
    ACT_OPCFG = 2'b01,
    ACT_LIMITS = 2'b10
  } word_action_t;

endpackage

// File: hw/word_shifter.sv
// Collects one programming word from host low pulses on the data pin.
// Assumes dataIn is synchronous and the pin is released while enabled.
`timescale 1ns/1ps
`include "rx_noise_cfg.svh"

module word_shifter (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control and pin
  input wire logic enable,
  input wire logic dataIn,
  // Result
  output logic [14:0] word,
  output logic wordDone,
  output logic abort
);

  logic [15:0] lowLen_q;
  logic [15:0] highLen_q;
  logic [3:0] bitCount_q;
  logic armed_q;
  logic prevIn_q;
  logic [14:0] word_q;
  logic riseSeen;
  logic newBit;
  logic lastBit;
  logic gapOut;
  logic wordDone_q;

  // A low pulse that ends at or after the split length is a one
  assign riseSeen = enable & dataIn & ~prevIn_q;
  assign newBit = (lowLen_q >= 16'(`BIT_SPLIT_CYC));
  assign lastBit = armed_q & riseSeen & (bitCount_q == 4'(`WORD_BITS - 1));
  assign gapOut = enable & armed_q & (highLen_q >= 16'(`BIT_GAP_CYC));
  assign word = word_q;
  assign wordDone = wordDone_q;
  assign abort = gapOut;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse length counters
  always_ff @(posedge clock) begin
    if (rst || !enable) begin
      lowLen_q <= 16'h0000;
      highLen_q <= 16'h0000;
      prevIn_q <= 1'b1;
    end else begin
      prevIn_q <= dataIn;
      lowLen_q <= dataIn ? 16'h0000 : lowLen_q + 16'h0001;
      highLen_q <= dataIn ? highLen_q + 16'h0001 : 16'h0000;
    end
  end

  // Bit 1 arrives first; the first rise only ends the entry pulse
  always_ff @(posedge clock) begin
    if (rst || !enable || lastBit || gapOut) begin
      armed_q <= 1'b0;
      bitCount_q <= 4'h0;
    end else if (riseSeen && !armed_q) begin
      armed_q <= 1'b1;
    end else if (riseSeen) begin
      bitCount_q <= bitCount_q + 4'h1;
    end
  end

  // Shift in at the low end so bit 1 ends at the top
  always_ff @(posedge clock) begin
    if (rst) begin
      word_q <= 15'h0000;
    end else if (armed_q && riseSeen) begin
      word_q <= {word_q[13:0], newBit};
    end
  end

  // Done one edge after the last rise, once the stop bit sits in the word
  always_ff @(posedge clock) begin
    if (rst || !enable) begin
      wordDone_q <= 1'b0;
    end else begin
      wordDone_q <= lastBit;
    end
  end

endmodule

// File: hw/rx_config_noise_control.sv
// Configuration registers and data pin noise control of a polling receiver.
// Assumes demodulator, bit checker and host pins are synchronous to clock.
//
// Behaviour
// - Squelch on, override high: end of stream enters check, pin high
// - Automatic squelch active straight after power-up
// - High last period gives one band-length trailing pulse
// - Squelch off: noise passes to pin after stream
// - Off with override low: start-up, skip sleep, check
// - Two volatile 12-bit configuration registers
// - Registers written only through the data pin
// - Corrupted registers flag marker; host reprograms both
// - Reset loads both register defaults
// - Bits 1 and 2 select off or register
// - Commit payload only when stop bit is zero
// - Operating register field layout and defaults
// - Bit-window minimum and maximum layout and defaults
// - Baud band picks window scale 8, 4, 2, 1
// - Check count code gives 0, 3, 6, 9 bits
// - Squelch bit one enables suppression, default one
// - Modulation bit zero FSK default, one ASK
// - Stretch bit multiplies sleep by one or eight
// - Sleep for counts 0 to 30 is count times stretch times 1024 clocks
`timescale 1ns/1ps
`include "rx_noise_cfg.svh"

module rx_config_noise_control #(
  parameter logic [19:0] SLEEP_UNIT_CYC = 20'(`SLEEP_UNIT),
  parameter logic [19:0] RESET_LOW_CYC = 20'(`RESET_LOW_CYC)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Data pin, open drain: enable high pulls the pin low
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOe,
  // Poll-override pin from the host, active low
  input wire logic pollOverride_n,
  // Demodulator and bit checker
  input wire logic demodData,
  input wire logic streamEnd,
  input wire logic checkPass,
  input wire logic checkFail,
  // Supply monitor
  input wire logic supplyDip,
  // Mode status
  output rx_noise_pkg::rx_state_t rxState,
  output logic icActive,
  output logic bitCheckActive,
  output logic receiving,
  // Configuration towards the receiver core
  output logic [1:0] rateBandSelect,
  output logic [3:0] windowScaleFactor,
  output logic [3:0] checkBitCount,
  output logic modulationSelect,
  output logic [4:0] sleepCount,
  output logic sleepStretch,
  output logic noiseSquelch,
  output logic [5:0] limitMin,
  output logic [5:0] limitMax,
  output logic corruptionMarker
);
  import rx_noise_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding functions

  // Band code to window scale factor
  function automatic logic [3:0] scaleOf(input logic [1:0] band);
    logic [3:0] s;
    s = 4'h8;
    unique case (band)
      2'b00: s = 4'h8;
      2'b01: s = 4'h4;
      2'b10: s = 4'h2;
      2'b11: s = 4'h1;
    endcase
    return s;
  endfunction

  // Check count code to number of bits
  function automatic logic [3:0] checkOf(input logic [1:0] code);
    logic [3:0] n;
    n = 4'h0;
    unique case (code)
      2'b00: n = 4'h0;
      2'b01: n = 4'h3;
      2'b10: n = 4'h6;
      2'b11: n = 4'h9;
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  rx_state_t state_q;
  rx_state_t state_d;
  logic [11:0] opCfg_q;
  logic [11:0] limits_q;
  logic [19:0] cnt_q;
  logic [19:0] lowRun_q;
  logic markerPending_q;
  logic pinLevel_q;
  logic pinLevel_d;
  logic pollPrev_q;
  logic [3:0] scale_q;
  logic [3:0] checkBits_q;
  logic [14:0] word;
  logic wordDone;
  logic wordAbort;
  logic hostLow;
  logic longLow;
  logic progEntry;
  logic pollRise;
  logic squelchOn;
  logic [1:0] bandCode;
  logic [1:0] chkCode;
  logic [4:0] sleepCode;
  logic stretchOn;
  logic [19:0] sleepLen;
  logic [19:0] tailLen;
  logic sleepOver;
  logic startupOver;
  logic tailOver;
  logic markerLow;
  logic checkSkip;
  word_action_t action;
  logic commit;
  logic wrOpCfg;
  logic wrLimits;
  logic cfgReload;

  ////////////////////////////////////////////////////////////////////////////
  // Word receiver

  word_shifter word_shifter_inst (
    .clock(clock),
    .rst(rst),
    .enable(state_q == ST_PROG),
    .dataIn(dataIn),
    .word(word),
    .wordDone(wordDone),
    .abort(wordAbort)
  );

  // Bit 1 set is off regardless of bit 2; otherwise bit 2 is the address
  assign action = word[`W_OFF] ? ACT_OFF :
                  (word[`W_ADDR] ? ACT_OPCFG : ACT_LIMITS);
  assign commit = wordDone & ~word[`W_STOP];
  assign wrOpCfg = commit & (action == ACT_OPCFG);
  assign wrLimits = commit & (action == ACT_LIMITS);

  ////////////////////////////////////////////////////////////////////////////
  // Field decode of the operating register

  assign bandCode = opCfg_q[`OP_BAND_HI:`OP_BAND_LO];
  assign chkCode = opCfg_q[`OP_CHK_HI:`OP_CHK_LO];
  assign sleepCode = opCfg_q[`OP_SLEEP_HI:`OP_SLEEP_LO];
  assign stretchOn = opCfg_q[`OP_STRETCH];
  assign squelchOn = opCfg_q[`OP_SQUELCH];

  // Sleep length in cycles, stretch multiplies by eight
  assign sleepLen = 20'(sleepCode) * (stretchOn ? 20'(`SLEEP_STRETCH) : 20'h0_0001)
                    * SLEEP_UNIT_CYC;

  // Trailing pulse scales with the band like the bit window
  assign tailLen = 20'(`TAIL_UNIT_CYC) * 20'(scaleOf(bandCode));

  ////////////////////////////////////////////////////////////////////////////
  // Pin and timer conditions

  // Host pull is only seen while this end releases the pin
  assign hostLow = ~dataIn & ~dataOe;
  assign longLow = (lowRun_q >= RESET_LOW_CYC);
  assign progEntry = hostLow & (lowRun_q == 20'(`PROG_ENTRY_CYC - 1)) &
                     ((state_q == ST_RECEIVE) | (state_q == ST_CHECK));
  assign pollRise = pollOverride_n & ~pollPrev_q;
  assign sleepOver = (sleepCode != `SLEEP_PERMANENT) & (cnt_q >= sleepLen);
  assign startupOver = (cnt_q >= 20'(`STARTUP_CYC - 1));
  assign tailOver = (cnt_q >= tailLen - 20'h0_0001);
  assign markerLow = markerPending_q & (cnt_q < 20'(`MARKER_CYC));
  assign checkSkip = (checkOf(chkCode) == 4'h0);
  assign cfgReload = rst | supplyDip | longLow;

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_SLEEP: begin
        // Override low wakes at once; else the sleep interval elapses
        if (!pollOverride_n || sleepOver) begin
          state_d = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (startupOver) begin
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (progEntry) begin
          state_d = ST_PROG;
        end else if (checkSkip || checkPass) begin
          state_d = ST_RECEIVE;
        end else if (checkFail && pollOverride_n) begin
          state_d = ST_SLEEP;
        end
      end
      ST_RECEIVE: begin
        if (progEntry) begin
          state_d = ST_PROG;
        end else if (!pollOverride_n) begin
          state_d = ST_RECEIVE;
        end else if (pollRise && !squelchOn) begin
          state_d = ST_SLEEP;
        end else if (streamEnd && squelchOn) begin
          state_d = demodData ? ST_TAIL : ST_CHECK;
        end
      end
      ST_TAIL: begin
        if (tailOver) begin
          state_d = ST_CHECK;
        end
      end
      ST_PROG: begin
        if (wordAbort) begin
          state_d = ST_CHECK;
        end else if (wordDone && action == ACT_OFF) begin
          // Override low skips the sleep and runs the check
          state_d = pollOverride_n ? ST_SLEEP : ST_STARTUP;
        end else if (wordDone) begin
          state_d = ST_CHECK;
        end
      end
      default: state_d = ST_SLEEP;
    endcase
  end

  // Pin level per mode; noise passes while receiving
  always_comb begin
    pinLevel_d = 1'b1;
    unique case (state_d)
      ST_RECEIVE: pinLevel_d = demodData;
      ST_TAIL: pinLevel_d = 1'b0;
      ST_CHECK: pinLevel_d = ~(markerPending_q & ~(wrOpCfg | wrLimits) &
                               (state_q != ST_CHECK | markerLow));
      default: pinLevel_d = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State, timer and pin registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= ST_SLEEP;
      cnt_q <= 20'h0_0000;
      pinLevel_q <= 1'b1;
      pollPrev_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? 20'h0_0000 :
               ((&cnt_q) ? cnt_q : cnt_q + 20'h0_0001);
      pinLevel_q <= pinLevel_d;
      pollPrev_q <= pollOverride_n;
    end
  end

  // Length of the current host low pulse
  always_ff @(posedge clock) begin
    if (rst || !hostLow) begin
      lowRun_q <= 20'h0_0000;
    end else if (!(&lowRun_q)) begin
      lowRun_q <= lowRun_q + 20'h0_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, defaults on reset or corruption
  always_ff @(posedge clock) begin
    if (cfgReload) begin
      opCfg_q <= `OPCFG_RESET;
      limits_q <= `LIMITS_RESET;
    end else begin
      if (wrOpCfg) begin
        opCfg_q <= word[`W_PAY_HI:`W_PAY_LO];
      end
      if (wrLimits) begin
        limits_q <= word[`W_PAY_HI:`W_PAY_LO];
      end
    end
  end

  // Marker stays until a register is rewritten; a new loss wins
  always_ff @(posedge clock) begin
    if (cfgReload) begin
      markerPending_q <= 1'b1;
    end else if (wrOpCfg || wrLimits) begin
      markerPending_q <= 1'b0;
    end
  end

  // Registered decodes for the receiver core
  always_ff @(posedge clock) begin
    if (rst) begin
      scale_q <= 4'h8;
      checkBits_q <= 4'h3;
    end else begin
      scale_q <= scaleOf(bandCode);
      checkBits_q <= checkOf(chkCode);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open drain pin: drive low only
  assign dataOut = 1'b0;
  assign dataOe = ~pinLevel_q;
  assign rxState = state_q;
  assign icActive = (state_q != ST_SLEEP);
  assign bitCheckActive = (state_q == ST_CHECK);
  assign receiving = (state_q == ST_RECEIVE);
  assign rateBandSelect = bandCode;
  assign windowScaleFactor = scale_q;
  assign checkBitCount = checkBits_q;
  assign modulationSelect = opCfg_q[`OP_MOD];
  assign sleepCount = sleepCode;
  assign sleepStretch = stretchOn;
  assign noiseSquelch = squelchOn;
  assign limitMin = limits_q[`LIM_MIN_HI:`LIM_MIN_LO];
  assign limitMax = limits_q[`LIM_MAX_HI:`LIM_MAX_LO];
  assign corruptionMarker = markerPending_q;

endmodule

// File: test/rx_noise_chk.sv
// Assertion checker for the receiver configuration and noise control block.
// Assumes a bind onto the top module; it sees only that module's ports.
`timescale 1ns/1ps
module rx_noise_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pin and receiver core inputs
  input wire logic dataOe,
  input wire logic pollOverride_n,
  input wire logic demodData,
  input wire logic streamEnd,
  input wire logic checkPass,
  input wire logic supplyDip,
  // Mode and configuration
  input rx_noise_pkg::rx_state_t rxState,
  input wire logic [1:0] rateBandSelect,
  input wire logic [3:0] windowScaleFactor,
  input wire logic [4:0] sleepCount,
  input wire logic noiseSquelch,
  input wire logic [5:0] limitMin,
  input wire logic [5:0] limitMax,
  input wire logic corruptionMarker
);
  import rx_noise_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic inRecv;
  logic inCheck;
  ////////////////////////////////////////////////////////////
  // Mode decodes
  assign inRecv = (rxState == ST_RECEIVE);
  assign inCheck = (rxState == ST_CHECK);
  // Register defaults and reload
  a_reset_defaults: assert property (
    $fell(rst) |-> noiseSquelch && corruptionMarker && limitMin == 6'h15 && limitMax == 6'h29)
    else $error("reset defaults wrong");
  a_dip_reload: assert property (supplyDip |=> corruptionMarker && sleepCount == 5'h06)
    else $error("dip reload missing");
  a_scale_map: assert property (windowScaleFactor == 4'h8 >> $past(rateBandSelect))
    else $error("scale factor wrong");
  // Pin behaviour per mode
  a_check_high: assert property (inCheck && $past(inCheck) && !corruptionMarker |-> !dataOe)
    else $error("pin low in check");
  a_recv_follow: assert property (inRecv && $past(inRecv) |-> dataOe == !$past(demodData))
    else $error("pin not following data");
  // End of stream handling with squelch on
  a_tail_start: assert property (
    inRecv && streamEnd && noiseSquelch && pollOverride_n && demodData |=> rxState == ST_TAIL)
    else $error("no trailing pulse");
  a_squelch_check: assert property (
    inRecv && streamEnd && noiseSquelch && pollOverride_n && !demodData |=> inCheck)
    else $error("no return to check");
  a_pass_receive: assert property (inCheck && checkPass |=> inRecv)
    else $error("check pass ignored");
  // Main scenarios reached
  c_tail: cover property (rxState == ST_TAIL);
  c_prog: cover property (rxState == ST_PROG);
  c_startup: cover property (rxState == ST_STARTUP);
endmodule

// File: test/rx_host_model.sv
// Host microcontroller model on the data and poll-override pins.
// Assumes an open-drain pin with pull-up; calls start just after an edge.
`timescale 1ns/1ps
module rx_host_model (
  // Clock
  input wire logic clock,
  // Pins
  input wire logic dataOe,
  output logic dataIn,
  output logic pollOverride_n
);
  logic hostLow;
  ////////////////////////////////////////////////////////////
  // Wired pin: either party pulls low, else pull-up
  assign dataIn = !(hostLow || dataOe);
  // Released pin and polling enabled; defaults need no programming
  initial begin
    hostLow = 1'b0;
    pollOverride_n = 1'b1;
  end
  // Hold the pin for a number of edges
  task automatic pin(input logic low, input int n);
    hostLow = low;
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Override low keeps receiving, high resumes polling
  task automatic ovr(input logic v);
    pollOverride_n = v;
  endtask
  // Entry pulse, arm, then bit 1 to bit 15; a long low is a one
  task automatic sendWord(input logic [14:0] w);
    int i;
    pin(1'b1, 90);
    pin(1'b0, 4);
    for (i = 14; i >= 0; i--) begin
      pin(1'b1, w[i] ? 50 : 10);
      pin(1'b0, 4);
    end
  endtask
endmodule

// File: test/rx_config_noise_control_tb_top.sv
// Testbench for the receiver configuration and noise control block.
// Assumes the host model on the pins and the checker bound below.
`timescale 1ns/1ps
module rx_config_noise_control_tb_top;
  import rx_noise_pkg::*;
  logic clock, rst, demodData, streamEnd, checkPass, checkFail, supplyDip;
  logic dataIn, dataOe, pollOverride_n, modulationSelect, sleepStretch, noiseSquelch;
  logic corruptionMarker;
  logic icActive, bitCheckActive, receiving;
  logic [1:0] rateBandSelect;
  logic [3:0] windowScaleFactor, checkBitCount;
  logic [4:0] sleepCount;
  logic [5:0] limitMin, limitMax;
  rx_state_t rxState;
  int badCount, samplesChecked;
  ////////////////////////////////////////////////////////////
  // Block and host
  rx_config_noise_control #(.SLEEP_UNIT_CYC(20'h0_0004), .RESET_LOW_CYC(20'h0_0258))
    rx_config_noise_control_inst (.clock(clock), .rst(rst), .dataIn(dataIn), .dataOut(),
    .dataOe(dataOe), .pollOverride_n(pollOverride_n), .demodData(demodData),
    .streamEnd(streamEnd), .checkPass(checkPass), .checkFail(checkFail),
    .supplyDip(supplyDip), .rxState(rxState), .icActive(icActive),
    .bitCheckActive(bitCheckActive), .receiving(receiving),
    .rateBandSelect(rateBandSelect), .windowScaleFactor(windowScaleFactor),
    .checkBitCount(checkBitCount), .modulationSelect(modulationSelect),
    .sleepCount(sleepCount), .sleepStretch(sleepStretch), .noiseSquelch(noiseSquelch),
    .limitMin(limitMin), .limitMax(limitMax), .corruptionMarker(corruptionMarker));
  rx_host_model rx_host_model_inst (.clock(clock), .dataOe(dataOe), .dataIn(dataIn),
    .pollOverride_n(pollOverride_n));
  // Clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic waitState(input rx_state_t s, input int n);
    int i;
    for (i = 0; i < n && rxState !== s; i++) tick(1);
    cmp(12'(rxState), 12'(s));
  endtask
  task automatic waitIdle();
    int i;
    for (i = 0; i < 900 && dataOe !== 1'b0; i++) tick(1);
  endtask
  task automatic pass();
    checkPass = 1'b1;
    tick(1);
    checkPass = 1'b0;
  endtask
  task automatic endOfTest();
    $display("checks=%0d mismatches=%0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic tDefaults();
    cmp(12'({rateBandSelect, checkBitCount, windowScaleFactor}), 12'h038);
    cmp(12'({modulationSelect, sleepStretch, noiseSquelch, sleepCount}), 12'h026);
    cmp(12'({limitMin, limitMax}), 12'h569);
    waitState(ST_CHECK, 1200);
    tick(2);
    cmp(12'(dataOe), 12'h001);
  endtask
  task automatic tOpWrites();
    int i;
    for (i = 3; i >= 0; i--) begin
      waitIdle();
      rx_host_model_inst.sendWord({2'h1, 2'(i), 2'(i), 1'h1, 5'h03, 1'h1, 2'h0});
      tick(2);
      cmp(12'({rateBandSelect, checkBitCount}), 12'({2'(i), 4'(3 * i)}));
      cmp(12'(windowScaleFactor), 12'(8 >> i));
    end
    cmp(12'({modulationSelect, sleepCount, sleepStretch, noiseSquelch}), 12'h08E);
    cmp(12'(corruptionMarker), 12'h000);
  endtask
  task automatic tLimits();
    waitIdle();
    rx_host_model_inst.sendWord({2'h0, 6'h0A, 6'h3E, 1'h1});
    tick(2);
    cmp(12'({limitMin, limitMax}), 12'h569);
    rx_host_model_inst.sendWord({2'h0, 6'h0A, 6'h3E, 1'h0});
    tick(2);
    cmp(12'({limitMin, limitMax}), 12'h2BE);
  endtask
  task automatic tNoise();
    pass();
    waitState(ST_RECEIVE, 4);
    demodData = 1'b0;
    streamEnd = 1'b1;
    tick(1);
    streamEnd = 1'b0;
    tick(1);
    cmp(12'({rxState, dataOe}), 12'({ST_RECEIVE, 1'h1}));
    cmp(12'({icActive, bitCheckActive, receiving}), 12'h005);
    demodData = 1'b1;
    rx_host_model_inst.ovr(1'b1);
    waitState(ST_SLEEP, 4);
    tick(90);
    cmp(12'(rxState), 12'(ST_SLEEP));
    waitState(ST_STARTUP, 12);
  endtask
  task automatic tOff();
    rx_host_model_inst.ovr(1'b0);
    waitState(ST_RECEIVE, 1200);
    rx_host_model_inst.sendWord({1'h1, 14'h0000});
    cmp(12'(rxState), 12'(ST_STARTUP));
    waitState(ST_RECEIVE, 1000);
  endtask
  task automatic tTail();
    int n;
    rx_host_model_inst.sendWord({2'h1, 2'h3, 2'h1, 1'h0, 5'h06, 1'h0, 1'h1, 1'h0});
    pass();
    rx_host_model_inst.ovr(1'b1);
    streamEnd = 1'b1;
    tick(1);
    streamEnd = 1'b0;
    cmp(12'({rxState, dataOe}), 12'({ST_TAIL, 1'h1}));
    for (n = 0; n < 400 && rxState === ST_TAIL; n++) tick(1);
    cmp(12'(n > 197 && n < 202), 12'h001);
    tick(2);
    cmp(12'({rxState, dataOe}), 12'({ST_CHECK, 1'h0}));
    cmp(12'({icActive, bitCheckActive, receiving}), 12'h006);
    pass();
    demodData = 1'b0;
    streamEnd = 1'b1;
    tick(1);
    streamEnd = 1'b0;
    demodData = 1'b1;
    cmp(12'(rxState), 12'(ST_CHECK));
  endtask
  task automatic tDip();
    supplyDip = 1'b1;
    tick(1);
    supplyDip = 1'b0;
    tick(2);
    cmp(12'({limitMin, limitMax}), 12'h569);
    cmp(12'({rateBandSelect, corruptionMarker, noiseSquelch}), 12'h003);
    // Failed check with polling enabled sleeps 6 x 1 x 4 cycles at defaults
    checkFail = 1'b1;
    tick(1);
    checkFail = 1'b0;
    cmp(12'({icActive, bitCheckActive, receiving, rxState}), 12'(ST_SLEEP));
    tick(23);
    cmp(12'(rxState), 12'(ST_SLEEP));
    waitState(ST_STARTUP, 3);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    badCount = 0;
    samplesChecked = 0;
    rst = 1'b1;
    demodData = 1'b1;
    streamEnd = 1'b0;
    checkPass = 1'b0;
    checkFail = 1'b0;
    supplyDip = 1'b0;
    tick(4);
    rst = 1'b0;
    rx_host_model_inst.ovr(1'b0);
    tDefaults();
    tOpWrites();
    tLimits();
    tNoise();
    tOff();
    tTail();
    tDip();
    endOfTest();
  end
  // Watchdog
  initial begin
    #1500000;
    badCount++;
    endOfTest();
  end
endmodule

bind rx_config_noise_control rx_noise_chk rx_noise_chk_inst (.clock(clock), .rst(rst),
  .dataOe(dataOe), .pollOverride_n(pollOverride_n), .demodData(demodData),
  .streamEnd(streamEnd), .checkPass(checkPass), .supplyDip(supplyDip), .rxState(rxState),
  .rateBandSelect(rateBandSelect), .windowScaleFactor(windowScaleFactor),
  .sleepCount(sleepCount), .noiseSquelch(noiseSquelch), .limitMin(limitMin),
  .limitMax(limitMax), .corruptionMarker(corruptionMarker));
